/* File: core/edge_detect.sv */
// Rising and falling edge detector for the capture trigger.
`timescale 1ns/1ps
`default_nettype none

module edge_detect (
  // System
  input wire logic clk,
  input wire logic rst,
  // Signal
  input wire logic din,
  output timer_pkg::edge_t edges
);

  logic prev_reg;
  logic prev_next;

  always_comb begin
    prev_next = din;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= prev_next;
    end
  end

  // One driver for the whole struct keeps strict tools from seeing two writers.
  assign edges = {din & ~prev_reg, ~din & prev_reg};

endmodule : edge_detect
`default_nettype wire

/* File: core/glitch_filter.sv */
// Pulse filter that passes a level only after it has stood for the filter time.
`timescale 1ns/1ps
`default_nettype none
`include "timer_defines.svh"

module glitch_filter (
  // System
  input wire logic clk,
  input wire logic rst,
  // Signal
  input wire logic din,
  output logic dout
);

  logic [1:0] count_reg;
  logic [1:0] count_next;
  logic dout_reg;
  logic dout_next;

  always_comb begin
    count_next = 2'b00;
    dout_next = dout_reg;
    if (din != dout_reg) begin
      count_next = count_reg + 2'b01;
      if (count_next == 2'(`FILT_CYCLES)) begin
        dout_next = din;
        count_next = 2'b00;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count_reg <= 2'b00;
      dout_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      dout_reg <= dout_next;
    end
  end

  assign dout = dout_reg;

endmodule : glitch_filter
`default_nettype wire

/* File: core/periodic_timer_unit.sv */
// Periodic timer with mode and output control, APB register slave.
`timescale 1ns/1ps
`default_nettype none
`include "timer_defines.svh"

// Function
// [R1] Mode field selects compare, capture, PWM, timer
// [R2] Software stops timer before changing mode
// [R3] Timer/counter mode output pin is undefined
// [R4] Compare match A: none, low, high, toggle
// [R5] Requested level equal initial gives no change
// [R6] Timer-on rising edge restores initial level
// [R7] PWM codes: inactive, active, waveform, single pulse
// [R8] Software changes PWM pin function only stopped
// [R9] Capture, plain clear: edge into match A
// [R10] Capture with edge clear: rise B, fall A
// [R11] Output control sets initial compare level
// [R12] Output control sets PWM active level
// [R13] Output control sets single-pulse start level
// [R14] Control and invert ignored in timer mode
// [R15] Invert bit inverts output pin level
// [R16] Capture source: input pin or clock/filter
// [R17] Clear source: match A, else P/overflow
// [R18] Overflow clear only when period is zero
// [R19] Clear source used only compare/timer modes
// [R20] Timer-on rise zeroes counter, fall holds
// [R21] Capture clear field adds edge clears
// [R22] Inversion applied after mode output logic
// [R23] All control fields reset to zero
module periodic_timer_unit (
  // System
  input wire logic clk,
  input wire logic rst,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins
  input wire logic capture_input_pin,
  input wire logic external_clock_pin,
  input wire logic noise_filter_data,
  output logic timer_output_pin
);

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == `ADDR_CTRL0) || (a == `ADDR_MOC) || (a == `ADDR_CTRL2) ||
              (a == `ADDR_COUNT) || (a == `ADDR_MATCH_A) || (a == `ADDR_MATCH_B) ||
              (a == `ADDR_PERIOD) || (a == `ADDR_FILT);
  endfunction : addr_ok

  // Bus-side control state.
  logic timer_on_bit_reg, timer_on_bit_next;
  timer_pkg::moc_t moc_reg, moc_next;
  logic [1:0] capture_clear_field_reg, capture_clear_field_next;
  logic filter_input_select_bit_reg, filter_input_select_bit_next;
  logic [15:0] period_reg, period_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;

  // Timer state.
  logic [15:0] cnt_reg, cnt_next;
  logic [15:0] match_a_register_reg, match_a_register_next;
  logic [15:0] second_capture_register_reg, second_capture_register_next;
  logic out_reg, out_next;
  logic pin_reg, pin_next;
  logic flag_reg, flag_next;
  logic on_prev_reg, on_prev_next;

  logic wr_fire;
  logic rd_take;
  logic on_rise;
  logic match_a;
  logic match_p;
  logic clr_hit;
  logic clk_filtered;
  logic cap_level;
  timer_pkg::edge_t cap_edge;

  glitch_filter u_filter (
    .clk(clk),
    .rst(rst),
    .din(external_clock_pin),
    .dout(clk_filtered)
  );

  // Capture trigger source selection.
  assign cap_level = moc_reg.cap_src ?
                     (filter_input_select_bit_reg ? noise_filter_data : clk_filtered) :
                     capture_input_pin; // [R16]

  edge_detect u_edge (
    .clk(clk),
    .rst(rst),
    .din(cap_level),
    .edges(cap_edge)
  );

  // The access phase takes two cycles: data are prepared, then pready is raised.
  assign rd_take = psel & penable & ~pready_reg;
  assign wr_fire = psel & penable & pready_reg & pwrite;

  always_comb begin
    timer_on_bit_next = timer_on_bit_reg;
    moc_next = moc_reg;
    capture_clear_field_next = capture_clear_field_reg;
    filter_input_select_bit_next = filter_input_select_bit_reg;
    period_next = period_reg;
    prdata_next = prdata_reg;
    pready_next = rd_take;
    pslverr_next = rd_take & ~addr_ok(paddr);
    if (rd_take && !pwrite) begin
      prdata_next = `WORD_ZERO;
      unique case (paddr)
        `ADDR_CTRL0: prdata_next[`ON_BIT] = timer_on_bit_reg;
        `ADDR_MOC: prdata_next[7:0] = moc_reg;
        `ADDR_CTRL2: prdata_next[2:0] = {capture_clear_field_reg, flag_reg};
        `ADDR_COUNT: prdata_next[15:0] = cnt_reg;
        `ADDR_MATCH_A: prdata_next[15:0] = match_a_register_reg;
        `ADDR_MATCH_B: prdata_next[15:0] = second_capture_register_reg;
        `ADDR_PERIOD: prdata_next[15:0] = period_reg;
        `ADDR_FILT: prdata_next[`FSEL_BIT] = filter_input_select_bit_reg;
        default: prdata_next = `WORD_ZERO;
      endcase
    end
    if (wr_fire) begin
      unique case (paddr)
        `ADDR_CTRL0: timer_on_bit_next = pwdata[`ON_BIT];
        `ADDR_MOC: moc_next = pwdata[7:0];
        `ADDR_CTRL2: capture_clear_field_next = pwdata[`CCF_MSB:`CCF_LSB];
        `ADDR_PERIOD: period_next = pwdata[15:0];
        `ADDR_FILT: filter_input_select_bit_next = pwdata[`FSEL_BIT];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      timer_on_bit_reg <= 1'b0;
      moc_reg <= `MOC_RESET; // [R23]
      capture_clear_field_reg <= 2'b00;
      filter_input_select_bit_reg <= 1'b0;
      period_reg <= `CNT_ZERO;
      prdata_reg <= `WORD_ZERO;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      timer_on_bit_reg <= timer_on_bit_next;
      moc_reg <= moc_next;
      capture_clear_field_reg <= capture_clear_field_next;
      filter_input_select_bit_reg <= filter_input_select_bit_next;
      period_reg <= period_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign on_rise = timer_on_bit_reg & ~on_prev_reg;
  // A zero match A value never matches, so the counter runs to overflow instead.
  assign match_a = (match_a_register_reg != `CNT_ZERO) && (cnt_reg == match_a_register_reg);
  // Comparator P is silent at zero so the counter wraps through overflow. [R18]
  assign match_p = (period_reg != `CNT_ZERO) && (cnt_reg == period_reg);

  always_comb begin
    clr_hit = match_p;
    unique case (moc_reg.mode)
      `MODE_CMP, `MODE_TMR: clr_hit = moc_reg.clr_src ? match_a : match_p; // [R17] [R19]
      `MODE_PWM: clr_hit = match_p; // [R19]
      `MODE_CAP: begin
        unique case (capture_clear_field_reg) // [R21]
          `CCF_ONLY_P: clr_hit = match_p;
          `CCF_RISE: clr_hit = match_p | cap_edge.rise;
          `CCF_FALL: clr_hit = match_p | cap_edge.fall;
          `CCF_BOTH: clr_hit = match_p | cap_edge.rise | cap_edge.fall;
        endcase
      end
    endcase
  end

  always_comb begin
    cnt_next = cnt_reg;
    out_next = out_reg;
    match_a_register_next = match_a_register_reg;
    second_capture_register_next = second_capture_register_reg;
    flag_next = flag_reg;
    on_prev_next = timer_on_bit_reg;
    if (wr_fire && paddr == `ADDR_MATCH_A) begin
      match_a_register_next = pwdata[15:0];
    end
    if (wr_fire && paddr == `ADDR_MATCH_B) begin
      second_capture_register_next = pwdata[15:0];
    end
    if (on_rise) begin
      cnt_next = `CNT_ZERO; // [R20]
      if (moc_reg.mode == `MODE_CMP || moc_reg.mode == `MODE_PWM) begin
        out_next = moc_reg.out_ctrl; // [R6] [R11] [R13]
      end
    end else if (timer_on_bit_reg) begin
      cnt_next = clr_hit ? `CNT_ZERO : cnt_reg + `CNT_ONE;
      unique case (moc_reg.mode) // [R1]
        `MODE_CMP: begin
          if (match_a) begin
            unique case (moc_reg.pin_fn) // [R4] [R5]
              `PIN_NONE: out_next = out_reg;
              `PIN_LOW: out_next = 1'b0;
              `PIN_HIGH: out_next = 1'b1;
              `PIN_TOGGLE: out_next = ~out_reg;
            endcase
          end
        end
        `MODE_PWM: begin
          unique case (moc_reg.pin_fn) // [R7] [R12]
            `PWM_INACT: out_next = ~moc_reg.out_ctrl;
            `PWM_ACT: out_next = moc_reg.out_ctrl;
            `PWM_WAVE: out_next = (cnt_reg < match_a_register_reg) ? moc_reg.out_ctrl : ~moc_reg.out_ctrl;
            `PWM_SINGLE: begin
              if (match_a) begin
                out_next = ~moc_reg.out_ctrl;
              end
            end
          endcase
        end
        `MODE_CAP: begin
          if (capture_clear_field_reg == `CCF_ONLY_P) begin
            unique case (moc_reg.pin_fn) // [R9]
              `CAP_RISE: if (cap_edge.rise) match_a_register_next = cnt_reg;
              `CAP_FALL: if (cap_edge.fall) match_a_register_next = cnt_reg;
              `CAP_BOTH: if (cap_edge.rise || cap_edge.fall) match_a_register_next = cnt_reg;
              `CAP_OFF: ;
            endcase
          end else begin
            unique case (moc_reg.pin_fn) // [R10]
              `CAP_RISE: begin
                if (cap_edge.rise) begin
                  second_capture_register_next = cnt_reg;
                  flag_next = 1'b1;
                end
              end
              `CAP_FALL: begin
                if (cap_edge.fall) begin
                  match_a_register_next = cnt_reg;
                  flag_next = 1'b0;
                end
              end
              `CAP_BOTH: begin
                if (cap_edge.rise) begin
                  second_capture_register_next = cnt_reg;
                  flag_next = 1'b1;
                end
                if (cap_edge.fall) begin
                  match_a_register_next = cnt_reg;
                  flag_next = 1'b0;
                end
              end
              `CAP_OFF: ;
            endcase
          end
        end
        `MODE_TMR: ;
      endcase
    end
    // The pin is simply held in timer mode; its level there carries no meaning.
    pin_next = (moc_reg.mode == `MODE_TMR) ? pin_reg : // [R3] [R14]
               out_next ^ moc_reg.out_inv; // [R15] [R22]
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_reg <= `CNT_ZERO;
      match_a_register_reg <= `CNT_ZERO;
      second_capture_register_reg <= `CNT_ZERO;
      out_reg <= 1'b0;
      pin_reg <= 1'b0;
      flag_reg <= 1'b0;
      on_prev_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      match_a_register_reg <= match_a_register_next;
      second_capture_register_reg <= second_capture_register_next;
      out_reg <= out_next;
      pin_reg <= pin_next;
      flag_reg <= flag_next;
      on_prev_reg <= on_prev_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign timer_output_pin = pin_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_timer_pin_hold: assert property ((moc_reg.mode == `MODE_TMR) |=> $stable(pin_reg)) // [R3]
    else $error("pin moved in timer mode");
  a_cmp_drive_low: assert property ( // [R4]
    (moc_reg.mode == `MODE_CMP) && timer_on_bit_reg && !on_rise &&
    match_a && moc_reg.pin_fn == `PIN_LOW |=> !out_reg)
    else $error("compare low not driven");
  a_cmp_toggle_out: assert property ( // [R4]
    (moc_reg.mode == `MODE_CMP) && timer_on_bit_reg && !on_rise &&
    match_a && moc_reg.pin_fn == `PIN_TOGGLE |=> out_reg != $past(out_reg))
    else $error("compare toggle missed");
  a_on_rise_init: assert property ( // [R6]
    on_rise && moc_reg.mode != `MODE_CAP && moc_reg.mode != `MODE_TMR
    |=> out_reg == $past(moc_reg.out_ctrl) && cnt_reg == `CNT_ZERO)
    else $error("timer start did not restore initial state");
  a_pwm_active_hold: assert property ( // [R12]
    (moc_reg.mode == `MODE_PWM) && timer_on_bit_reg && moc_reg.pin_fn == `PWM_ACT
    |=> out_reg == $past(moc_reg.out_ctrl))
    else $error("pwm active level wrong");
  a_pin_after_invert: assert property ( // [R22]
    (moc_reg.mode != `MODE_TMR) |=> pin_reg == (out_reg ^ $past(moc_reg.out_inv)))
    else $error("pin not inverted output level");
  a_clear_on_a: assert property ( // [R17]
    (moc_reg.mode == `MODE_CMP) && timer_on_bit_reg && !on_rise &&
    moc_reg.clr_src && match_a |=> cnt_reg == `CNT_ZERO)
    else $error("match A clear missed");
  a_clear_on_p: assert property ( // [R17]
    (moc_reg.mode == `MODE_CMP) && timer_on_bit_reg && !on_rise &&
    !moc_reg.clr_src && match_p |=> cnt_reg == `CNT_ZERO)
    else $error("match P clear missed");
  a_pwm_ignore_clr: assert property ( // [R19]
    (moc_reg.mode == `MODE_PWM) && timer_on_bit_reg && !on_rise &&
    !match_p |=> cnt_reg == $past(cnt_reg) + `CNT_ONE)
    else $error("clear source acted in pwm mode");
  a_cap_rise_a: assert property ( // [R9]
    (moc_reg.mode == `MODE_CAP) && timer_on_bit_reg && !on_rise &&
    capture_clear_field_reg == `CCF_ONLY_P && moc_reg.pin_fn == `CAP_RISE && cap_edge.rise
    |=> match_a_register_reg == $past(cnt_reg))
    else $error("rising capture into match A missed");
  a_cap_rise_b: assert property ( // [R10]
    (moc_reg.mode == `MODE_CAP) && timer_on_bit_reg && !on_rise &&
    capture_clear_field_reg != `CCF_ONLY_P && moc_reg.pin_fn == `CAP_RISE && cap_edge.rise
    |=> second_capture_register_reg == $past(cnt_reg) && flag_reg)
    else $error("rising capture into second register missed");

  c_pwm_wave: cover property ((moc_reg.mode == `MODE_PWM) && timer_on_bit_reg &&
    moc_reg.pin_fn == `PWM_WAVE ##1 $changed(pin_reg));
  c_capture_a: cover property ((moc_reg.mode == `MODE_CAP) && timer_on_bit_reg
    ##1 $changed(match_a_register_reg));
  c_cmp_toggle: cover property ((moc_reg.mode == `MODE_CMP) && match_a &&
    moc_reg.pin_fn == `PIN_TOGGLE);

endmodule : periodic_timer_unit
`default_nettype wire

/* File: pkg/timer_defines.svh */
// Register offsets, field codes and timing constants of the periodic timer unit.
`ifndef TIMER_DEFINES_SVH
`define TIMER_DEFINES_SVH

`define ADDR_CTRL0 8'h00
`define ADDR_MOC 8'h04
`define ADDR_CTRL2 8'h08
`define ADDR_COUNT 8'h0C
`define ADDR_MATCH_A 8'h10
`define ADDR_MATCH_B 8'h14
`define ADDR_PERIOD 8'h18
`define ADDR_FILT 8'h1C

`define ON_BIT 3
`define CCF_MSB 2
`define CCF_LSB 1
`define FLAG_BIT 0
`define FSEL_BIT 0
`define MOC_RESET 8'h00

`define MODE_CMP 2'b00
`define MODE_CAP 2'b01
`define MODE_PWM 2'b10
`define MODE_TMR 2'b11

`define PIN_NONE 2'b00
`define PIN_LOW 2'b01
`define PIN_HIGH 2'b10
`define PIN_TOGGLE 2'b11

`define PWM_INACT 2'b00
`define PWM_ACT 2'b01
`define PWM_WAVE 2'b10
`define PWM_SINGLE 2'b11

`define CAP_RISE 2'b00
`define CAP_FALL 2'b01
`define CAP_BOTH 2'b10
`define CAP_OFF 2'b11

`define CCF_ONLY_P 2'b00
`define CCF_RISE 2'b01
`define CCF_FALL 2'b10
`define CCF_BOTH 2'b11

`define CNT_ZERO 16'h0000
`define CNT_ONE 16'h0001
`define WORD_ZERO 32'h0000_0000

`define FILT_TIME_NS 150
`define CLK_PERIOD_NS 100
`define FILT_CYCLES ((`FILT_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* File: pkg/timer_pkg.sv */
// Shared types of the periodic timer unit.
package timer_pkg;

  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] pin_fn;
    logic out_ctrl;
    logic out_inv;
    logic cap_src;
    logic clr_src;
  } moc_t;

  typedef struct packed {
    logic rise;
    logic fall;
  } edge_t;

endpackage : timer_pkg

/* File: verification/tb_top.sv */
// Self-checking testbench of the periodic timer unit, driven over APB and its pins.
`timescale 1ns/1ps
`default_nettype none
`include "timer_defines.svh"

module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic cap_in = 1'b0;
  logic ext_clk = 1'b0;
  logic nf_dat = 1'b0;
  logic out_pin;
  logic [31:0] rd;
  logic er;
  logic [31:0] held;
  int miscompares = 0;
  int checks_done = 0;
  int cycles = 0;
  int highs;
  // Each entry is a control value, the pin level just after start and the level after match A.
  localparam logic [9:0] OUT_TAB [14] = '{
    {8'h20, 2'b01}, {8'h20, 2'b01}, {8'h18, 2'b10}, {8'h30, 2'b01}, {8'h08, 2'b11},
    {8'h28, 2'b11}, {8'hCC, 2'b11}, {8'h24, 2'b10}, {8'h88, 2'b00}, {8'h98, 2'b11},
    {8'h90, 2'b00}, {8'h80, 2'b11}, {8'h9C, 2'b00}, {8'hB8, 2'b10}};

  always #50 clk = ~clk;

  periodic_timer_unit uut (
    .clk(clk),
    .rst(rst),
    .paddr(paddr),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .capture_input_pin(cap_in),
    .external_clock_pin(ext_clk),
    .noise_filter_data(nf_dat),
    .timer_output_pin(out_pin)
  );

  task automatic finish_test();
    $display("checks_done %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test

  // A hung handshake would otherwise stall the run forever.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares = miscompares + 1;
      $display("CHECK FAILED run time expected below 20000 seen %0d", cycles);
      finish_test();
    end
  end

  task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check_word

  task automatic check_bit(input string what, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask : check_bit

  task automatic check_range(input string what, input logic [15:0] lo, input logic [15:0] hi,
                             input logic [15:0] got);
    checks_done++;
    if ((got >= lo) !== 1'b1 || (got <= hi) !== 1'b1) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h to %h seen %h", what, lo, hi, got);
    end
  endtask : check_range

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check_word(what, exp, rd);
  endtask : rdc

  // The timer is always stopped before its mode or pin function changes.
  task automatic restart(input logic [7:0] moc);
    wr(`ADDR_CTRL0, 32'h0000_0000);
    wr(`ADDR_MOC, {24'h00_0000, moc});
    wr(`ADDR_CTRL0, 32'h0000_0008);
  endtask : restart

  task automatic cap_run(input logic [7:0] moc, input logic [7:0] ccf, input int src,
                         input logic [15:0] alo, input logic [15:0] ahi,
                         input logic [15:0] blo, input logic [15:0] bhi);
    wr(`ADDR_CTRL0, 32'h0000_0000);
    wr(`ADDR_CTRL2, {24'h00_0000, ccf});
    wr(`ADDR_FILT, (src == 2) ? 32'h0000_0001 : 32'h0000_0000);
    wr(`ADDR_MATCH_A, 32'h0000_ABCD);
    wr(`ADDR_MATCH_B, 32'h0000_ABCD);
    restart(moc);
    repeat (20) @(posedge clk);
    {nf_dat, ext_clk, cap_in} <= 3'b001 << src;
    repeat (20) @(posedge clk);
    {nf_dat, ext_clk, cap_in} <= 3'b000;
    repeat (8) @(posedge clk);
    apb(1'b0, `ADDR_MATCH_A, 32'h0000_0000);
    check_range("match a capture", alo, ahi, rd[15:0]);
    apb(1'b0, `ADDR_MATCH_B, 32'h0000_0000);
    check_range("match b capture", blo, bhi, rd[15:0]);
  endtask : cap_run

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rdc("control reset", `ADDR_MOC, 32'h0000_0000);
    rdc("capture clear reset", `ADDR_CTRL2, 32'h0000_0000);
    wr(`ADDR_MOC, 32'h0000_00FF);
    rdc("control readback", `ADDR_MOC, 32'h0000_00FF);
    check_bit("mapped access error", 1'b0, er);
    apb(1'b0, 8'h20, 32'h0000_0000);
    check_bit("unmapped read error", 1'b1, er);
    check_word("unmapped read data", 32'h0000_0000, rd);
    wr(8'h20, 32'h0000_FFFF);
    check_bit("unmapped write error", 1'b1, er);
    wr(`ADDR_MATCH_A, 32'h0000_0010);
    for (int i = 0; i < 14; i++) begin
      restart(OUT_TAB[i][9:2]);
      repeat (3) @(posedge clk);
      check_bit("pin at start", OUT_TAB[i][1], out_pin);
      repeat (30) @(posedge clk);
      check_bit("pin after match", OUT_TAB[i][0], out_pin);
    end
    wr(`ADDR_PERIOD, 32'h0000_0040);
    restart(8'hA8);
    highs = 0;
    repeat (130) begin
      @(posedge clk);
      highs += (out_pin === 1'b1) ? 1 : 0;
    end
    check_range("pwm active cycles", 16'h0018, 16'h0028, 16'(highs));
    wr(`ADDR_MATCH_A, 32'h0000_000A);
    wr(`ADDR_PERIOD, 32'h0000_0014);
    restart(8'h01);
    repeat (6) begin
      apb(1'b0, `ADDR_COUNT, 32'h0000_0000);
      check_range("count clear a", 16'h0000, 16'h000A, rd[15:0]);
    end
    restart(8'h00);
    repeat (6) begin
      apb(1'b0, `ADDR_COUNT, 32'h0000_0000);
      check_range("count clear p", 16'h0000, 16'h0014, rd[15:0]);
    end
    wr(`ADDR_PERIOD, 32'h0000_0000);
    restart(8'h00);
    repeat (40) @(posedge clk);
    apb(1'b0, `ADDR_COUNT, 32'h0000_0000);
    check_range("count no period", 16'h0015, 16'hFFFF, rd[15:0]);
    wr(`ADDR_PERIOD, 32'h0000_0040);
    restart(8'h81);
    repeat (30) @(posedge clk);
    apb(1'b0, `ADDR_COUNT, 32'h0000_0000);
    check_range("count pwm", 16'h000B, 16'h0040, rd[15:0]);
    wr(`ADDR_CTRL0, 32'h0000_0000);
    apb(1'b0, `ADDR_COUNT, 32'h0000_0000);
    held = rd;
    wr(`ADDR_COUNT, 32'h0000_1234);
    repeat (10) @(posedge clk);
    rdc("count held", `ADDR_COUNT, held);
    wr(`ADDR_CTRL0, 32'h0000_0008);
    apb(1'b0, `ADDR_COUNT, 32'h0000_0000);
    check_range("count restart", 16'h0000, 16'h0008, rd[15:0]);
    cap_run(8'h40, 8'h00, 0, 16'h000F, 16'h001E, 16'hABCD, 16'hABCD);
    cap_run(8'h50, 8'h00, 0, 16'h0024, 16'h0034, 16'hABCD, 16'hABCD);
    cap_run(8'h60, 8'h00, 0, 16'h0024, 16'h0034, 16'hABCD, 16'hABCD);
    cap_run(8'h70, 8'h00, 0, 16'hABCD, 16'hABCD, 16'hABCD, 16'hABCD);
    cap_run(8'h40, 8'h04, 0, 16'hABCD, 16'hABCD, 16'h000F, 16'h001E);
    rdc("latch flag rise", `ADDR_CTRL2, 32'h0000_0005);
    cap_run(8'h50, 8'h02, 0, 16'h000F, 16'h001E, 16'hABCD, 16'hABCD);
    rdc("latch flag fall", `ADDR_CTRL2, 32'h0000_0002);
    cap_run(8'h60, 8'h04, 0, 16'h0024, 16'h0034, 16'h000F, 16'h001E);
    cap_run(8'h60, 8'h06, 0, 16'h000F, 16'h001E, 16'h000F, 16'h001E);
    cap_run(8'h42, 8'h00, 0, 16'hABCD, 16'hABCD, 16'hABCD, 16'hABCD);
    cap_run(8'h42, 8'h00, 1, 16'h000F, 16'h001E, 16'hABCD, 16'hABCD);
    cap_run(8'h42, 8'h00, 2, 16'h000F, 16'h001E, 16'hABCD, 16'hABCD);
    finish_test();
  end
endmodule : tb_top

`default_nettype wire
